//--- common/pmb_pkg.sv
package pmb_pkg;
  // configuration-space offsets of the three base registers
  localparam logic [7:0] HOST_CTRL_REGS_BASE_OFS = 8'h10;
  localparam logic [7:0] VENDOR_EXT_REGS_BASE_OFS = 8'h14;
  localparam logic [7:0] CARD_INFO_WINDOW_BASE_OFS = 8'h18;
  // field layout: programmable upper bits, read-only low bits
  localparam int BASE_UPPER_LSB = 11;
  localparam int BASE_UPPER_W = 21;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] BASE_WRITE_MASK = 32'hFFFF_F800;
  localparam logic [20:0] UPPER_RESET = 21'h00_0000;
  // low-bit fields, all read as zero
  localparam logic [6:0] SIZE_FIELD_VAL = 7'h00;
  localparam logic PREFETCH_FLAG_VAL = 1'b0;
  localparam logic [1:0] LOCATE_TYPE_VAL = 2'h0;
  localparam logic SPACE_FLAG_VAL = 1'b0;

  // configuration access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } pmb_cfg_req_type;

  // memory-space claims
  typedef struct packed {
    logic hostHit;
    logic vendorHit;
    logic cardHit;
  } pmb_claim_type;
endpackage

//--- verilog/pmb_base_regs.sv
`timescale 1ns/1ps
// Operation
// - all-ones write to host-controller base reads back FFFF_F800
// - host base bits 31..11 read/write, hold upper 21 address bits
// - host base bits 10..4 read zero, 2-Kbyte size
// - host base bit 3 reads zero, nonprefetchable
// - host base bits 2..1 read zero, 32-bit anywhere placement
// - host base bit 0 reads zero, memory space
// - vendor extension base at 14h behaves like host base
// - strap high at reset: card window base reads all zero, read-only
// - strap low at reset: card window bits 31..11 writable
// - card window bits 10..4 read zero, 2-Kbyte size
// - card window bits 3..0 read zero
module pmb_base_regs (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cardModeStrap,
  input wire pmb_pkg::pmb_cfg_req_type cfgReq,
  input wire logic memValid,
  input wire logic [31:0] memAddr,
  output logic [31:0] cfgRdata,
  output logic cfgRdValid,
  output pmb_pkg::pmb_claim_type claim,
  output logic cardWindowDisabled
);

  logic [20:0] hostRegsBaseUpper_r;
  logic [20:0] vendorRegsBaseUpper_r;
  logic [20:0] cardWindowBaseUpper_r;
  logic strapCaught_r;
  logic [31:0] rdNxt;

  // merge upper bits under byte enables; low bits never stored
  function automatic logic [20:0] mergeUpper(input logic [20:0] cur,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] full;
    full = {cur, 11'h000};
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        full[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return full[31:11];
  endfunction

  // full register image with read-only zero fields appended
  function automatic logic [31:0] image(input logic [20:0] up);
    return {up, pmb_pkg::SIZE_FIELD_VAL, pmb_pkg::PREFETCH_FLAG_VAL,
            pmb_pkg::LOCATE_TYPE_VAL, pmb_pkg::SPACE_FLAG_VAL};
  endfunction

  function automatic logic isWrite(input pmb_pkg::pmb_cfg_req_type r,
                                   input logic [7:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // strap is caught while reset is held, so it tracks the pin until release
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strapCaught_r <= cardModeStrap;
    end
  end

  // host-controller register base
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hostRegsBaseUpper_r <= pmb_pkg::UPPER_RESET;
    end else if (isWrite(cfgReq, pmb_pkg::HOST_CTRL_REGS_BASE_OFS)) begin
      hostRegsBaseUpper_r <= mergeUpper(hostRegsBaseUpper_r, cfgReq.wdata,
                                        cfgReq.byteEn);
    end
  end

  // vendor extension base, same layout
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vendorRegsBaseUpper_r <= pmb_pkg::UPPER_RESET;
    end else if (isWrite(cfgReq, pmb_pkg::VENDOR_EXT_REGS_BASE_OFS)) begin
      vendorRegsBaseUpper_r <= mergeUpper(vendorRegsBaseUpper_r, cfgReq.wdata,
                                          cfgReq.byteEn);
    end
  end

  // card window base; writes dropped while strap disables it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cardWindowBaseUpper_r <= pmb_pkg::UPPER_RESET;
    end else if (strapCaught_r) begin
      cardWindowBaseUpper_r <= pmb_pkg::UPPER_RESET;
    end else if (isWrite(cfgReq, pmb_pkg::CARD_INFO_WINDOW_BASE_OFS)) begin
      cardWindowBaseUpper_r <= mergeUpper(cardWindowBaseUpper_r, cfgReq.wdata,
                                          cfgReq.byteEn);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdNxt = pmb_pkg::BASE_RESET;
    case (cfgReq.addr)
      // image() fills the read-only zero fields
      pmb_pkg::HOST_CTRL_REGS_BASE_OFS: rdNxt = image(hostRegsBaseUpper_r);
      pmb_pkg::VENDOR_EXT_REGS_BASE_OFS: rdNxt = image(vendorRegsBaseUpper_r);
      pmb_pkg::CARD_INFO_WINDOW_BASE_OFS: begin
        rdNxt = strapCaught_r ? pmb_pkg::BASE_RESET
                              : image(cardWindowBaseUpper_r);
      end
      default: rdNxt = pmb_pkg::BASE_RESET;
    endcase
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cfgRdata <= pmb_pkg::BASE_RESET;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdata <= cfgReq.rd ? rdNxt : pmb_pkg::BASE_RESET;
      cfgRdValid <= cfgReq.rd;
    end
  end

  // address decode; a zero card base is never claimed, since software
  // must program it first and zero would alias low memory
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      claim <= '0;
      cardWindowDisabled <= 1'b0;
    end else begin
      claim.hostHit <= memValid && (memAddr[31:11] == hostRegsBaseUpper_r);
      claim.vendorHit <= memValid && (memAddr[31:11] == vendorRegsBaseUpper_r);
      claim.cardHit <= memValid && !strapCaught_r
                       && (cardWindowBaseUpper_r != pmb_pkg::UPPER_RESET)
                       && (memAddr[31:11] == cardWindowBaseUpper_r);
      cardWindowDisabled <= strapCaught_r;
    end
  end

  // byte-only access to the card window is the accessor's duty
  // no check here, wider accesses simply give undefined data downstream

  // steps of the write-then-read checks; the read lands one cycle after the write
  sequence seqHostAllOnesWr;
    cfgReq.wr && cfgReq.addr == pmb_pkg::HOST_CTRL_REGS_BASE_OFS
    && cfgReq.byteEn == 4'hF && cfgReq.wdata == 32'hFFFF_FFFF;
  endsequence
  sequence seqHostRd;
    cfgReq.rd && cfgReq.addr == pmb_pkg::HOST_CTRL_REGS_BASE_OFS;
  endsequence
  sequence seqVendorFullWr;
    cfgReq.wr && cfgReq.addr == pmb_pkg::VENDOR_EXT_REGS_BASE_OFS && cfgReq.byteEn == 4'hF;
  endsequence
  sequence seqVendorRd;
    cfgReq.rd && cfgReq.addr == pmb_pkg::VENDOR_EXT_REGS_BASE_OFS;
  endsequence

  // register readback and storage
  AST_HOST_ALLONES: assert property (@(posedge clock) disable iff (sys_rst)
    seqHostAllOnesWr ##1 seqHostRd
    |=> cfgRdValid && cfgRdata == pmb_pkg::BASE_WRITE_MASK)
    else $error("host base all-ones readback wrong");
  AST_HOST_LOW_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
    seqHostRd |=> cfgRdata[10:0] == 11'h000)
    else $error("host base low bits not zero");
  AST_HOST_STORE: assert property (@(posedge clock) disable iff (sys_rst)
    cfgReq.wr && cfgReq.addr == pmb_pkg::HOST_CTRL_REGS_BASE_OFS && cfgReq.byteEn == 4'hF
    |=> hostRegsBaseUpper_r == $past(cfgReq.wdata[31:11]))
    else $error("host base upper bits not stored");
  AST_HOST_PF: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRdValid && $past(cfgReq.addr) == pmb_pkg::HOST_CTRL_REGS_BASE_OFS
    |-> !cfgRdata[3] && !cfgRdata[0])
    else $error("host prefetch or space bit set");
  AST_HOST_TYPE: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRdValid && $past(cfgReq.addr) == pmb_pkg::HOST_CTRL_REGS_BASE_OFS
    |-> cfgRdata[2:1] == 2'b00)
    else $error("host locate type nonzero");
  AST_HOST_MEM: assert property (@(posedge clock) disable iff (sys_rst)
    cfgRdValid |-> !cfgRdata[0])
    else $error("space flag set");
  AST_VENDOR_STORE: assert property (@(posedge clock) disable iff (sys_rst)
    seqVendorFullWr ##1 seqVendorRd
    |=> cfgRdata == ($past(cfgReq.wdata, 2) & pmb_pkg::BASE_WRITE_MASK))
    else $error("vendor base readback wrong");
  AST_VENDOR_LOW: assert property (@(posedge clock) disable iff (sys_rst)
    seqVendorRd |=> cfgRdata[10:0] == 11'h000)
    else $error("vendor base low bits not zero");
  AST_CARD_OFF: assert property (@(posedge clock) disable iff (sys_rst)
    strapCaught_r && cfgReq.rd && cfgReq.addr == pmb_pkg::CARD_INFO_WINDOW_BASE_OFS
    |=> cfgRdata == pmb_pkg::BASE_RESET && !claim.cardHit)
    else $error("disabled card window not zero");
  AST_CARD_HELD_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
    strapCaught_r |-> cardWindowBaseUpper_r == pmb_pkg::UPPER_RESET)
    else $error("disabled card window base took a write");
  AST_STRAP_COPY: assert property (@(posedge clock) disable iff (sys_rst)
    1'b1 |=> cardWindowDisabled == $past(strapCaught_r))
    else $error("card window disable flag lost the strap");
  AST_CARD_STORE: assert property (@(posedge clock) disable iff (sys_rst)
    !strapCaught_r && cfgReq.wr && cfgReq.addr == pmb_pkg::CARD_INFO_WINDOW_BASE_OFS
    && cfgReq.byteEn == 4'hF
    |=> cardWindowBaseUpper_r == $past(cfgReq.wdata[31:11]))
    else $error("card base not stored");
  AST_CARD_LOW: assert property (@(posedge clock) disable iff (sys_rst)
    cfgReq.rd && cfgReq.addr == pmb_pkg::CARD_INFO_WINDOW_BASE_OFS
    |=> cfgRdata[10:0] == 11'h000)
    else $error("card low bits not zero");

  // memory-space claims follow the stored bases one cycle later
  AST_HOST_CLAIM: assert property (@(posedge clock) disable iff (sys_rst)
    memValid && memAddr[31:11] == hostRegsBaseUpper_r
    && !(cfgReq.wr && cfgReq.addr == pmb_pkg::HOST_CTRL_REGS_BASE_OFS) |=> claim.hostHit)
    else $error("host region not claimed");
  AST_HOST_NO_CLAIM: assert property (@(posedge clock) disable iff (sys_rst)
    memAddr[31:11] != hostRegsBaseUpper_r |=> !claim.hostHit)
    else $error("host region claimed outside its base");
  AST_VENDOR_CLAIM: assert property (@(posedge clock) disable iff (sys_rst)
    memValid && memAddr[31:11] == vendorRegsBaseUpper_r |=> claim.vendorHit)
    else $error("vendor region not claimed");
  AST_CARD_CLAIM: assert property (@(posedge clock) disable iff (sys_rst)
    memValid && !strapCaught_r && cardWindowBaseUpper_r != pmb_pkg::UPPER_RESET
    && memAddr[31:11] == cardWindowBaseUpper_r |=> claim.cardHit)
    else $error("card window not claimed");
  AST_CARD_ZERO_BASE: assert property (@(posedge clock) disable iff (sys_rst)
    cardWindowBaseUpper_r == pmb_pkg::UPPER_RESET || strapCaught_r |=> !claim.cardHit)
    else $error("unprogrammed or disabled card window claimed");
  AST_IDLE_NO_CLAIM: assert property (@(posedge clock) disable iff (sys_rst)
    !memValid |=> claim == '0)
    else $error("claim without a memory access");

endmodule

//--- sim/pmb_host_model.sv
`timescale 1ns/1ps
// configuration master and memory initiator on the host side
module pmb_host_model (
  input wire logic clock,
  output pmb_pkg::pmb_cfg_req_type cfgReq,
  output logic memValid,
  output logic [31:0] memAddr
);
  initial begin
    cfgReq = '0;
    memValid = 1'b0;
    memAddr = 32'h0000_0000;
  end
  // one-cycle config pulse, lanes chosen by the caller, dropped at the taking edge
  task automatic cfgAcc(input logic rd, input logic [7:0] ofs, input logic [31:0] wd,
                        input logic [3:0] be);
    cfgReq <= '{rd: rd, wr: !rd, addr: ofs, byteEn: be, wdata: wd};
    @(posedge clock);
    cfgReq <= '0;
  endtask
  // write then read on consecutive edges, the read must see the new value
  task automatic cfgWrRd(input logic [7:0] ofs, input logic [31:0] wd);
    cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: ofs, byteEn: 4'hF, wdata: wd};
    @(posedge clock);
    cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: ofs, byteEn: 4'hF, wdata: 32'h0000_0000};
    @(posedge clock);
    cfgReq <= '0;
  endtask
  // one-cycle memory probe, also used while the card base is still zero; no access width carried
  task automatic memAcc(input logic [31:0] a);
    memValid <= 1'b1;
    memAddr <= a;
    @(posedge clock);
    memValid <= 1'b0;
    memAddr <= ~a; // released bus shows junk, not the old address
  endtask
endmodule

//--- sim/pmb_base_regs_tb.sv
`timescale 1ns/1ps
module pmb_base_regs_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic cardModeStrap = 1'b0;
  pmb_pkg::pmb_cfg_req_type cfgReq;
  logic memValid;
  logic [31:0] memAddr;
  logic [31:0] cfgRdata;
  logic cfgRdValid;
  pmb_pkg::pmb_claim_type claim;
  logic cardWindowDisabled;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [7:0] OFS [3] = '{pmb_pkg::HOST_CTRL_REGS_BASE_OFS,
    pmb_pkg::VENDOR_EXT_REGS_BASE_OFS, pmb_pkg::CARD_INFO_WINDOW_BASE_OFS};
  pmb_base_regs pmb_base_regs_inst (.clock(clock), .sys_rst(sys_rst),
    .cardModeStrap(cardModeStrap), .cfgReq(cfgReq), .memValid(memValid),
    .memAddr(memAddr), .cfgRdata(cfgRdata), .cfgRdValid(cfgRdValid),
    .claim(claim), .cardWindowDisabled(cardWindowDisabled));
  pmb_host_model pmb_host_model_inst (.clock(clock), .cfgReq(cfgReq),
    .memValid(memValid), .memAddr(memAddr));
  // 100 ns period
  always #50 clock = ~clock;
  // hang guard, the run needs about 75 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // strap caught while reset is high, copy shows after release
  task automatic doReset(input logic s);
    @(posedge clock);
    sys_rst <= 1'b1;
    cardModeStrap <= s;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    check({31'h0000_0000, cardWindowDisabled}, {31'h0000_0000, s});
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    wrBe(ofs, d, 4'hF);
  endtask
  task automatic wrBe(input logic [7:0] ofs, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    pmb_host_model_inst.cfgAcc(1'b0, ofs, d, be);
  endtask
  // back-to-back write and read, answer looked at just after it lands
  task automatic wrRdChk(input logic [7:0] ofs, input logic [31:0] d, input logic [31:0] exp);
    @(posedge clock);
    pmb_host_model_inst.cfgWrRd(ofs, d);
    #1;
    check({31'h0000_0000, cfgRdValid}, 32'h0000_0001);
    check(cfgRdata, exp);
  endtask
  // answer stands one cycle, looked at just after it lands
  task automatic rdChk(input logic [7:0] ofs, input logic [31:0] exp, input logic v);
    @(posedge clock);
    pmb_host_model_inst.cfgAcc(1'b1, ofs, 32'h0000_0000, 4'hF);
    #1;
    check({31'h0000_0000, cfgRdValid}, {31'h0000_0000, v});
    check(cfgRdata, exp);
  endtask
  task automatic memChk(input logic [31:0] a, input logic [2:0] exp);
    @(posedge clock);
    pmb_host_model_inst.memAcc(a);
    #1;
    check({29'h0000_0000, claim}, {29'h0000_0000, exp});
  endtask
  task automatic tResetVals();
    for (int i = 0; i < 3; i++) rdChk(OFS[i], pmb_pkg::BASE_RESET, 1'b1);
    rdChk(8'h1C, 32'h0000_0000, 1'b1); // unmapped place still answers, with zero
    memChk(32'h0000_0100, 3'b110); // zero card base never claimed
  endtask
  task automatic tAllOnes();
    for (int i = 0; i < 3; i++) begin
      wrRdChk(OFS[i], 32'hFFFF_FFFF, 32'hFFFF_F800);
    end
  endtask
  // low eleven bits written as ones must read back zero
  task automatic tLowBits();
    for (int i = 0; i < 3; i++) begin
      wr(OFS[i], 32'h1234_5FFF);
      rdChk(OFS[i], 32'h1234_5800, 1'b1);
    end
  endtask
  // 2-Kbyte edges of three adjacent regions
  task automatic tClaims();
    wr(OFS[0], 32'h4000_0000);
    wr(OFS[1], 32'h4000_0800);
    wr(OFS[2], 32'h4000_1000);
    memChk(32'h4000_07FF, 3'b100);
    memChk(32'h4000_0800, 3'b010);
    memChk(32'h4000_17FF, 3'b001);
    memChk(32'h4000_1800, 3'b000);
  endtask
  // single lanes: lane 1 carries bits 15..11, lane 0 is all read-only
  task automatic tBytes();
    wrBe(OFS[0], 32'hFFFF_FFFF, 4'h2);
    rdChk(OFS[0], 32'h4000_F800, 1'b1);
    wrBe(OFS[0], 32'hFFFF_FFFF, 4'h1);
    rdChk(OFS[0], 32'h4000_F800, 1'b1);
    wrBe(OFS[0], 32'h0000_0000, 4'h8);
    rdChk(OFS[0], 32'h0000_F800, 1'b1);
    memChk(32'h0000_F800, 3'b100);
  endtask
  task automatic tStrapHigh();
    doReset(1'b1);
    wr(OFS[2], 32'hFFFF_FFFF);
    rdChk(OFS[2], 32'h0000_0000, 1'b1);
    wr(OFS[0], 32'h0000_0800);
    memChk(32'h0000_0800, 3'b100);
  endtask
  initial begin
    doReset(1'b0);
    tResetVals();
    tAllOnes();
    tLowBits();
    tClaims();
    tBytes();
    tStrapHigh();
    test_done();
  end
endmodule
